// ===== logic/scph_config_header.sv
// Notes on behaviour
// - answers configuration accesses for function five
// - standard header, 60h-FCh reserved
// - fixed maker code at 00h, writes ignored
// - fixed function code at 02h, read-only
// - some bits cleared by global reset only
// - memory accesses answered only while enabled
// - writing one clears status flag, zero keeps
`timescale 1ns/1ns
`default_nettype none
module scph_config_header #(
  parameter logic [2:0]  FUNC_NUM   = 3'h5,
  parameter logic [15:0] MAKER_CODE = 16'h1234,  // arbitrary value
  parameter logic [15:0] FUNC_CODE  = 16'h5678,  // arbitrary value
  parameter logic [7:0]  REVISION   = 8'h00,
  parameter logic [23:0] CLASS_CODE = 24'h000000,
  parameter logic [15:0] PWR_CAPS   = 16'h0002,
  parameter int          WIN_BITS   = 12
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  input  wire logic                   nglobal_reset_in,
  input  wire scph_pkg::scph_cfg_req_t cfg_req_in,
  input  wire scph_pkg::scph_mem_req_t mem_req_in,
  input  wire logic [2:0]             status_event_in,
  input  wire logic                   int_pending_in,
  input  wire logic                   pme_event_in,
  output logic                        cfg_ack_out,
  output logic [31:0]                 cfg_rdata_out,
  output logic                        mem_hit_out,
  output logic [1:0]                  power_state_out
);
  import scph_pkg::*;

  // the window mask shift needs at least one kept base bit and four masked bits
  if (WIN_BITS < 4 || WIN_BITS > 31) begin : g_win_bits_check
    $error("WIN_BITS out of range");
  end

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        mem_hit;
    logic [15:0] cmd;
    logic [2:0]  flags;
    logic [31:0] gbase;
    logic [31:0] sbase;
    logic [7:0]  int_line;
    logic [1:0]  pwr;
    logic        pme_en;
    logic        pme_sts;
    logic [15:0] gen_ctl;
    logic [31:0] subsys;
    logic [23:0] class_code;
    logic [31:0] setup1;
    logic [31:0] setup2;
  } scph_state_t;

  localparam logic [31:0] WIN_MASK = ~((32'h1 << WIN_BITS) - 32'h1);

  scph_state_t st_r;
  scph_state_t st_nxt;

  function automatic logic [31:0] scph_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[i*8 +: 8] = wd[i*8 +: 8];
    end
    return m;
  endfunction : scph_merge

  function automatic logic off_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : off_hit

  function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base);
    return (a & WIN_MASK) == (base & WIN_MASK);
  endfunction : win_hit

  logic        sel;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [7:0]  ad;
  logic [15:0] stat_rd;
  logic [31:0] clr;
  logic [31:0] mrg;

  always_comb begin
    st_nxt  = st_r;
    sel     = cfg_req_in.valid && (cfg_req_in.func == FUNC_NUM);
    wr      = sel && cfg_req_in.write;
    wd      = cfg_req_in.wdata;
    be      = cfg_req_in.be;
    ad      = cfg_req_in.addr;
    clr     = wr ? (wd & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}) : 32'h0;
    mrg     = 32'h0;
    stat_rd = STAT_FIXED;
    stat_rd[STAT_INT_BIT] = int_pending_in;
    stat_rd[STAT_F0_BIT]  = st_r.flags[0];
    stat_rd[STAT_F1_BIT]  = st_r.flags[1];
    stat_rd[STAT_F2_BIT]  = st_r.flags[2];

    st_nxt.ack   = sel;
    st_nxt.rdata = 32'h0;
    if (sel && !cfg_req_in.write) begin
      if (off_hit(ad, OFF_IDENT)) begin
        st_nxt.rdata = {FUNC_CODE, MAKER_CODE};
      end else if (off_hit(ad, OFF_CMD_STAT)) begin
        st_nxt.rdata = {stat_rd, st_r.cmd};
      end else if (off_hit(ad, OFF_CLASS_REV)) begin
        st_nxt.rdata = {st_r.class_code, REVISION};
      end else if (off_hit(ad, OFF_HDR)) begin
        st_nxt.rdata = {8'h00, HDR_MULTIFUNC, 16'h0000};
      end else if (off_hit(ad, OFF_GLOBAL_WIN)) begin
        st_nxt.rdata = st_r.gbase;
      end else if (off_hit(ad, OFF_SOCKET1)) begin
        st_nxt.rdata = st_r.sbase;
      end else if (off_hit(ad, OFF_SUBSYS) || off_hit(ad, OFF_SUBSYS_AL)) begin
        st_nxt.rdata = st_r.subsys;
      end else if (off_hit(ad, OFF_CAP_START)) begin
        st_nxt.rdata = {24'h0, CAP_PTR};
      end else if (off_hit(ad, OFF_INT_LAT)) begin
        st_nxt.rdata = {16'h0, INT_PIN_A, st_r.int_line};
      end else if (off_hit(ad, OFF_PWR_HEAD)) begin
        st_nxt.rdata = {PWR_CAPS, 8'h00, CAP_ID_PWR};
      end else if (off_hit(ad, OFF_PWR_CTL)) begin
        st_nxt.rdata = {8'h00, PWR_BRIDGE_EXT, st_r.pme_sts, 6'h0, st_r.pme_en, 6'h0, st_r.pwr};
      end else if (off_hit(ad, OFF_GEN_CTL)) begin
        st_nxt.rdata = {16'h0, st_r.gen_ctl};
      end else if (off_hit(ad, OFF_CLASS_AL)) begin
        st_nxt.rdata = {8'h00, st_r.class_code};
      end else if (off_hit(ad, OFF_SETUP1)) begin
        st_nxt.rdata = st_r.setup1;
      end else if (off_hit(ad, OFF_SETUP2)) begin
        st_nxt.rdata = st_r.setup2;
      end
    end

    // writes; identity, fixed and reserved locations fall through untouched
    if (wr) begin
      if (off_hit(ad, OFF_CMD_STAT)) begin
        mrg        = scph_merge(32'(st_r.cmd), wd, be);
        st_nxt.cmd = mrg[15:0] & CMD_WR_MASK;
      end else if (off_hit(ad, OFF_GLOBAL_WIN)) begin
        st_nxt.gbase = scph_merge(st_r.gbase, wd, be) & WIN_MASK;
      end else if (off_hit(ad, OFF_SOCKET1)) begin
        st_nxt.sbase = scph_merge(st_r.sbase, wd, be) & WIN_MASK;
      end else if (off_hit(ad, OFF_INT_LAT)) begin
        mrg             = scph_merge(32'(st_r.int_line), wd, be);
        st_nxt.int_line = mrg[7:0];
      end else if (off_hit(ad, OFF_PWR_CTL)) begin
        mrg           = scph_merge(32'(st_r.pwr) | (32'(st_r.pme_en) << PWR_PME_EN), wd, be);
        st_nxt.pwr    = mrg[1:0];
        st_nxt.pme_en = mrg[PWR_PME_EN];
      end else if (off_hit(ad, OFF_GEN_CTL)) begin
        mrg            = scph_merge(32'(st_r.gen_ctl), wd, be);
        st_nxt.gen_ctl = mrg[15:0];
      end else if (off_hit(ad, OFF_SUBSYS_AL)) begin
        st_nxt.subsys = scph_merge(st_r.subsys, wd, be);
      end else if (off_hit(ad, OFF_CLASS_AL)) begin
        mrg               = scph_merge({8'h00, st_r.class_code}, wd, be);
        st_nxt.class_code = mrg[23:0];
      end else if (off_hit(ad, OFF_SETUP1)) begin
        st_nxt.setup1 = scph_merge(st_r.setup1, wd, be);
      end else if (off_hit(ad, OFF_SETUP2)) begin
        st_nxt.setup2 = scph_merge(st_r.setup2, wd, be);
      end
    end

    // clear by one, an event in the same cycle wins
    if (wr && off_hit(ad, OFF_CMD_STAT)) begin
      st_nxt.flags[0] = st_r.flags[0] & ~clr[16 + STAT_F0_BIT];
      st_nxt.flags[1] = st_r.flags[1] & ~clr[16 + STAT_F1_BIT];
      st_nxt.flags[2] = st_r.flags[2] & ~clr[16 + STAT_F2_BIT];
    end
    st_nxt.flags = st_nxt.flags | status_event_in;
    if (wr && off_hit(ad, OFF_PWR_CTL)) begin
      st_nxt.pme_sts = st_r.pme_sts & ~clr[PWR_PME_STS];
    end
    st_nxt.pme_sts = st_nxt.pme_sts | pme_event_in;

    st_nxt.mem_hit = mem_req_in.valid && st_r.cmd[CMD_MEM_EN] &&
                     (win_hit(mem_req_in.addr, st_r.gbase) || win_hit(mem_req_in.addr, st_r.sbase));

    if (!nglobal_reset_in) begin
      st_nxt = '0;
      st_nxt.class_code = CLASS_CODE;
    end else if (!nrst_in) begin
      // function reset keeps the subsystem pair, wake state and general control
      st_nxt            = '0;
      st_nxt.class_code = CLASS_CODE;
      st_nxt.subsys     = st_r.subsys;
      st_nxt.pme_en     = st_r.pme_en;
      st_nxt.pme_sts    = st_r.pme_sts;
      st_nxt.gen_ctl    = st_r.gen_ctl;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_r <= st_nxt;
  end

  assign cfg_ack_out     = st_r.ack;
  assign cfg_rdata_out   = st_r.rdata;
  assign mem_hit_out     = st_r.mem_hit;
  assign power_state_out = st_r.pwr;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in || !nglobal_reset_in);

  sequence seq_read(logic [7:0] off);
    cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.func == FUNC_NUM && off_hit(cfg_req_in.addr, off);
  endsequence

  AST_OTHER_FUNC: assert property (cfg_req_in.func != FUNC_NUM |=> !cfg_ack_out)
    else $error("answered another function");
  AST_OWN_FUNC: assert property (cfg_req_in.valid && cfg_req_in.func == FUNC_NUM |=> cfg_ack_out)
    else $error("own function not answered");
  AST_RSV_ZERO: assert property (cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr >= OFF_RSV_FIRST
                                 |=> cfg_rdata_out == 32'h0)
    else $error("reserved read not zero");
  AST_IDENT: assert property (seq_read(OFF_IDENT) |=> cfg_rdata_out == {FUNC_CODE, MAKER_CODE})
    else $error("identity codes wrong");
  AST_IDENT_FIXED: assert property (seq_read(OFF_IDENT) ##2 seq_read(OFF_IDENT)
                                    |=> cfg_rdata_out == $past(cfg_rdata_out, 2))
    else $error("identity read changed");
  AST_MEM_OFF: assert property (!st_r.cmd[CMD_MEM_EN] |=> !mem_hit_out)
    else $error("memory answered while disabled");
  AST_RSV_WRITE: assert property (wr && ad >= OFF_RSV_FIRST |=> $stable(st_r.setup1) && $stable(st_r.cmd))
    else $error("reserved write changed state");
  AST_W1C: assert property (wr && off_hit(ad, OFF_CMD_STAT) && clr[16 + STAT_F0_BIT] && !status_event_in[0]
                            |=> !st_r.flags[0])
    else $error("flag not cleared by one");
  AST_SET_WINS: assert property (status_event_in[2] |=> st_r.flags[2] [*1])
    else $error("event lost");
  AST_STICKY: assert property (@(posedge clk_sys_in) disable iff (!nglobal_reset_in)
                               !nrst_in && st_r.pme_sts |=> st_r.pme_sts)
    else $error("global-only bit lost on function reset");

endmodule : scph_config_header
`default_nettype wire

// ===== logic/scph_pkg.sv
package scph_pkg;

  // configuration byte offsets of the function header
  localparam logic [7:0] OFF_IDENT      = 8'h00;
  localparam logic [7:0] OFF_CMD_STAT   = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV  = 8'h08;
  localparam logic [7:0] OFF_HDR        = 8'h0c;
  localparam logic [7:0] OFF_GLOBAL_WIN = 8'h10;
  localparam logic [7:0] OFF_SOCKET1    = 8'h18;
  localparam logic [7:0] OFF_SUBSYS     = 8'h2c;
  localparam logic [7:0] OFF_CAP_START  = 8'h34;
  localparam logic [7:0] OFF_INT_LAT    = 8'h3c;
  localparam logic [7:0] OFF_PWR_HEAD   = 8'h44;
  localparam logic [7:0] OFF_PWR_CTL    = 8'h48;
  localparam logic [7:0] OFF_GEN_CTL    = 8'h4c;
  localparam logic [7:0] OFF_SUBSYS_AL  = 8'h50;
  localparam logic [7:0] OFF_CLASS_AL   = 8'h54;
  localparam logic [7:0] OFF_SETUP1     = 8'h58;
  localparam logic [7:0] OFF_SETUP2     = 8'h5c;
  localparam logic [7:0] OFF_RSV_FIRST  = 8'h60;

  // command register fields
  localparam logic [15:0] CMD_WR_MASK   = 16'h0542;
  localparam int          CMD_MEM_EN    = 1;
  // status register: fixed part, live interrupt bit and clear-by-one flag positions
  localparam logic [15:0] STAT_FIXED    = 16'h0210;
  localparam int          STAT_INT_BIT  = 3;
  localparam int          STAT_F0_BIT   = 11;
  localparam int          STAT_F1_BIT   = 14;
  localparam int          STAT_F2_BIT   = 15;

  localparam logic [7:0]  HDR_MULTIFUNC = 8'h80;
  localparam logic [7:0]  CAP_PTR       = 8'h44;
  localparam logic [7:0]  CAP_ID_PWR    = 8'h01;
  localparam logic [7:0]  INT_PIN_A     = 8'h01;
  // power control fields
  localparam int          PWR_PME_EN    = 8;
  localparam int          PWR_PME_STS   = 15;
  localparam logic [7:0]  PWR_BRIDGE_EXT = 8'h00;
  localparam logic [3:0]  BE_ALL        = 4'hf;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  func;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } scph_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } scph_cfg_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } scph_mem_req_t;

endpackage : scph_pkg

// ===== verification/scph_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module scph_host_model (
  input  wire logic                   clk_sys_in,
  input  wire logic                   ack_in,
  input  wire logic [31:0]            rdata_in,
  output var scph_pkg::scph_cfg_req_t req_out
);
  import scph_pkg::*;
  logic        got_ack;
  logic [31:0] got_data;
  initial req_out = '0;
  // one configuration transfer; ack and data stand only in the cycle after the take edge
  task automatic cfg(input logic wr, input logic [2:0] fn, input logic [7:0] ad, input logic [31:0] wd);
    @(negedge clk_sys_in);
    req_out <= '{valid: 1'b1, write: wr, func: fn, addr: ad, be: BE_ALL, wdata: wd};
    @(negedge clk_sys_in);
    got_ack  = ack_in;
    got_data = rdata_in;
    // released lines show the inverse so a stale value cannot pass
    req_out <= '{valid: 1'b0, write: ~wr, func: ~fn, addr: ~ad, be: 4'h0, wdata: ~wd};
  endtask : cfg
endmodule : scph_host_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import scph_pkg::*;
  logic          clk_sys_in, nrst_in, nglobal_reset_in, int_pending_in, pme_event_in;
  logic [2:0]    status_event_in;
  scph_cfg_req_t cfg_req;
  scph_mem_req_t mem_req;
  logic          cfg_ack, mem_hit;
  logic [31:0]   cfg_rdata;
  logic [1:0]    power_state;
  int            bad_count = 0;
  int            checks = 0;
  int            cycles = 0;
  logic [7:0]    rsv [3] = '{8'h30, 8'h60, 8'hfc};

  scph_host_model host (.clk_sys_in(clk_sys_in), .ack_in(cfg_ack), .rdata_in(cfg_rdata), .req_out(cfg_req));
  scph_config_header #(.MAKER_CODE(16'h1234), .FUNC_CODE(16'h5678)) DUT (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .nglobal_reset_in(nglobal_reset_in),
    .cfg_req_in(cfg_req), .mem_req_in(mem_req), .status_event_in(status_event_in),
    .int_pending_in(int_pending_in), .pme_event_in(pme_event_in), .cfg_ack_out(cfg_ack),
    .cfg_rdata_out(cfg_rdata), .mem_hit_out(mem_hit), .power_state_out(power_state));

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    host.cfg(1'b0, 3'h5, ad, 32'h0);
    chk("ack", 32'h1, {31'h0, host.got_ack});
    chk($sformatf("rdata %h", ad), exp, host.got_data);
  endtask : rd
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    host.cfg(1'b1, 3'h5, ad, wd);
    chk("ack", 32'h1, {31'h0, host.got_ack});
  endtask : wr
  task automatic mem(input logic [31:0] ad, input logic exp);
    @(negedge clk_sys_in);
    mem_req <= '{valid: 1'b1, addr: ad};
    @(negedge clk_sys_in);
    chk("mem_hit", {31'h0, exp}, {31'h0, mem_hit});
    mem_req <= '{valid: 1'b0, addr: ~ad};
  endtask : mem
  task automatic rst(input logic glob);
    @(negedge clk_sys_in);
    nrst_in = 1'b0;
    nglobal_reset_in = ~glob;
    repeat (3) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    nglobal_reset_in = 1'b1;
  endtask : rst

  task automatic t_ident();
    rd(OFF_IDENT, 32'h5678_1234);
    rd(8'h02, 32'h5678_1234);
    wr(OFF_IDENT, 32'hffff_ffff);
    rd(OFF_IDENT, 32'h5678_1234);
  endtask : t_ident
  task automatic t_func();
    for (int f = 0; f < 8; f++) begin
      host.cfg(1'b0, f[2:0], OFF_IDENT, 32'h0);
      chk("ack per function", {31'h0, f == 5}, {31'h0, host.got_ack});
    end
  endtask : t_func
  task automatic t_rsv();
    foreach (rsv[i]) begin
      wr(rsv[i], 32'hffff_ffff);
      rd(rsv[i], 32'h0);
    end
  endtask : t_rsv
  task automatic t_mem();
    rd(OFF_CMD_STAT, 32'h0210_0000);
    mem(32'h0001_0abc, 1'b0);
    wr(OFF_SOCKET1, 32'h0001_0000);
    mem(32'h0001_0abc, 1'b0);
    wr(OFF_CMD_STAT, 32'h0000_0002);
    mem(32'h0001_0abc, 1'b1);
    mem(32'h0002_0000, 1'b0);
  endtask : t_mem
  task automatic t_w1c();
    @(negedge clk_sys_in);
    status_event_in = 3'b111;
    int_pending_in = 1'b1;
    @(negedge clk_sys_in);
    status_event_in = 3'b000;
    rd(OFF_CMD_STAT, 32'hca18_0002);
    wr(OFF_CMD_STAT, 32'h0000_0002);
    rd(OFF_CMD_STAT, 32'hca18_0002);
    wr(OFF_CMD_STAT, 32'h0800_0002);
    rd(OFF_CMD_STAT, 32'hc218_0002);
    wr(OFF_CMD_STAT, 32'hc000_0002);
    int_pending_in = 1'b0;
    rd(OFF_CMD_STAT, 32'h0210_0002);
  endtask : t_w1c
  task automatic t_global_reset();
    wr(OFF_SUBSYS_AL, 32'h9abc_def0);
    wr(OFF_GEN_CTL, 32'h0000_abcd);
    wr(OFF_PWR_CTL, 32'h0000_0103);
    @(negedge clk_sys_in);
    pme_event_in = 1'b1;
    @(negedge clk_sys_in);
    pme_event_in = 1'b0;
    rd(OFF_PWR_CTL, 32'h0000_8103);
    chk("power_state", 32'h3, {30'h0, power_state});
    rst(1'b0);
    rd(OFF_GEN_CTL, 32'h0000_abcd);
    rd(OFF_SUBSYS, 32'h9abc_def0);
    rd(OFF_PWR_CTL, 32'h0000_8100);
    rd(OFF_CMD_STAT, 32'h0210_0000);
    rst(1'b1);
    rd(OFF_GEN_CTL, 32'h0);
    rd(OFF_PWR_CTL, 32'h0);
    rd(OFF_SUBSYS, 32'h0);
  endtask : t_global_reset
  task automatic t_map();
    rd(OFF_HDR, 32'h0080_0000);
    rd(OFF_CAP_START, 32'h0000_0044);
    rd(OFF_PWR_HEAD, 32'h0002_0001);
    wr(OFF_INT_LAT, 32'hffff_ff5a);
    rd(OFF_INT_LAT, 32'h0000_015a);
    wr(OFF_GLOBAL_WIN, 32'hffff_ffff);
    rd(OFF_GLOBAL_WIN, 32'hffff_f000);
    wr(OFF_CLASS_AL, 32'hffa1_b2c3);
    rd(OFF_CLASS_REV, 32'ha1b2_c300);
    rd(OFF_CLASS_AL, 32'h00a1_b2c3);
    wr(OFF_SETUP1, 32'h1357_9bdf);
    wr(OFF_SETUP2, 32'h2468_ace0);
    rd(OFF_SETUP1, 32'h1357_9bdf);
    rd(OFF_SETUP2, 32'h2468_ace0);
  endtask : t_map

  initial begin
    nrst_in = 1'b0;
    nglobal_reset_in = 1'b0;
    int_pending_in = 1'b0;
    pme_event_in = 1'b0;
    status_event_in = 3'b000;
    mem_req = '0;
    repeat (3) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    nglobal_reset_in = 1'b1;
    t_ident();
    t_func();
    t_rsv();
    t_mem();
    t_w1c();
    t_global_reset();
    t_map();
    results();
  end
endmodule : testbench
`default_nettype wire
